// file: tb_tx_and_hw_config_regs.sv
// Self-checking bench for the config register block
`timescale 1ns/1ps
module tb_tx_and_hw_config_regs;
    import txhw_cfg_pkg::*;
    `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
        $display("ERROR %0t got %0h want %0h", $time, a, b); end end
    logic        CLK = 1'h0, NRST = 1'h0, STRAP = 1'h1, PHY = 1'h0, BUSY = 1'h0, FULL = 1'h0;
    logic        WR, RD, EN, OK, HALT, EVT, PORD, SORD, SRO, SF, DF, MSB;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0]  ALLOC;
    logic [14:0] DB, SB, RB;
    int          n_fail = 0, num_checks = 0;
    always #25 CLK = ~CLK;
    txhw_host u_txhw_host (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
    tx_hw_config_regs #(.SOFT_RESET_TRIGGER_TIMEOUT(16)) u_tx_hw_config_regs (.CLK(CLK), .NRST(NRST),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CROSSOVER_STRAP(STRAP),
        .PHY_CLOCKS_OK(PHY), .TX_FRAME_BUSY(BUSY), .TX_STATUS_FULL(FULL), .TX_ENABLE(EN),
        .TX_SEND_OK(OK), .TX_HALTED(HALT), .TX_STATUS_FULL_EVENT(EVT), .TX_STATUS_FLUSH(SF),
        .TX_DATA_FLUSH(DF), .PORT_BYTE_ORDER(PORD), .SELECT_BYTE_ORDER(SORD), .MUST_SET_BIT(MSB),
        .TX_ALLOC(ALLOC), .TX_DATA_BYTES(DB), .TX_STAT_BYTES(SB), .RX_TOTAL_BYTES(RB),
        .SOFT_RESET_OUT(SRO));
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait ran out
    task automatic give_up;
        n_fail++;
        $display("ERROR %0t wait ran out", $time);
        finish_test();
    endtask
    // Values after reset
    task automatic t_reset;
        u_txhw_host.rd(TX_CTRL_OFFSET, d);
        `CHK(d, 32'h0)
        u_txhw_host.rd(HARDWARE_CONFIGURATION_OFFSET, d);
        `CHK(d, 32'h0105_0000)
        `CHK(DB, 15'h1200)
        `CHK(RB, 15'h2c00)
        $display("test reset done");
    endtask
    // Share codes 2 to 14, reserved bits, flushes, unmapped place
    task automatic t_alloc;
        for (int k = 2; k <= 14; k++) begin
            u_txhw_host.wr(HARDWARE_CONFIGURATION_OFFSET, 32'hfff0_fffe | (32'(k) << 16));
            u_txhw_host.rd(HARDWARE_CONFIGURATION_OFFSET, d);
            `CHK(d, 32'h3110_0000 | (32'(k) << 16))
            `CHK(DB, 15'(k * KB_BYTES - STATUS_QUEUE_BYTES))
            `CHK(SB, 15'(STATUS_QUEUE_BYTES))
            `CHK(RB, 15'(TOTAL_BUFFER_BYTES - k * KB_BYTES))
        end
        `CHK({PORD, SORD, MSB}, 3'h7)
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'hffff_c000);
        `CHK({SF, DF}, 2'h3)
        u_txhw_host.rd(TX_CTRL_OFFSET, d);
        `CHK(d, 32'h0)
        `CHK({SF, DF}, 2'h0)
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'h0000_4000);
        `CHK({SF, DF}, 2'h1)
        u_txhw_host.rd(8'h78, d);
        `CHK(d, 32'h0)
        $display("test alloc done");
    endtask
    // Enable, overrun permission, stop during a frame
    task automatic t_tx;
        @(posedge CLK) BUSY <= 1'h1;
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'h2);
        `CHK({EN, OK, HALT, SF, DF}, 5'h18)
        @(posedge CLK) FULL <= 1'h1;
        #1 `CHK({OK, EVT}, 2'h1)
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'h6);
        `CHK({OK, EVT}, 2'h3)
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'h7);
        `CHK(OK, 1'h0)
        u_txhw_host.wr(TX_CTRL_OFFSET, 32'h6);
        u_txhw_host.rd(TX_CTRL_OFFSET, d);
        `CHK(d, 32'h7)
        @(posedge CLK) BUSY <= 1'h0;
        FULL <= 1'h0;
        for (int i = 0; i < 4 && EN !== 1'h0; i++) @(posedge CLK) #1;
        if (EN !== 1'h0) give_up();
        `CHK(HALT, 1'h1)
        u_txhw_host.rd(TX_CTRL_OFFSET, d);
        `CHK(d, 32'h4)
        $display("test tx done");
    endtask
    // Soft reset timing out, then completing
    task automatic t_soft_reset_trigger;
        u_txhw_host.wr(HARDWARE_CONFIGURATION_OFFSET, 32'h301e_0001);
        repeat (24) @(posedge CLK);
        u_txhw_host.rd(HARDWARE_CONFIGURATION_OFFSET, d);
        `CHK(d, 32'h311e_0002)
        @(posedge CLK) PHY <= 1'h1;
        u_txhw_host.wr(HARDWARE_CONFIGURATION_OFFSET, 32'h301e_0001);
        for (int i = 0; i < 8 && SRO !== 1'h1; i++) @(posedge CLK) #1;
        if (SRO !== 1'h1) give_up();
        for (int i = 0; i < 12 && SRO !== 1'h0; i++) @(posedge CLK) #1;
        if (SRO !== 1'h0) give_up();
        u_txhw_host.rd(HARDWARE_CONFIGURATION_OFFSET, d);
        `CHK(d, 32'h3105_0000)
        u_txhw_host.rd(TX_CTRL_OFFSET, d);
        `CHK(d, 32'h0)
        $display("test soft reset done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge CLK);
        NRST <= 1'h1;
        t_reset();
        t_alloc();
        t_tx();
        t_soft_reset_trigger();
        finish_test();
    end
endmodule // tb_tx_and_hw_config_regs

// file: tx_buffer_split.sv
// Splits the shared buffer into transmit status, transmit data and receive space
`timescale 1ns/1ps
module tx_buffer_split
    import txhw_cfg_pkg::*;
(
    input  wire logic                   CLK,            // System clock
    input  wire logic                   NRST,           // Async reset, active low
    input  wire logic [HWC_ALLOC_W-1:0] ALLOC,          // Transmit allocation in KB
    output logic      [BUF_BYTES_W-1:0] TX_DATA_BYTES,  // Transmit data queue size
    output logic      [BUF_BYTES_W-1:0] TX_STAT_BYTES,  // Transmit status queue size
    output logic      [BUF_BYTES_W-1:0] RX_TOTAL_BYTES  // Receive status plus data size
);
    logic [BUF_BYTES_W-1:0] tx_total;

    // Total transmit share in bytes
    assign tx_total = BUF_BYTES_W'(ALLOC) * BUF_BYTES_W'(KB_BYTES);

    // Registered split of the buffer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_DATA_BYTES  <= '0;
            TX_STAT_BYTES  <= '0;
            RX_TOTAL_BYTES <= '0;
        end else begin
            TX_STAT_BYTES  <= BUF_BYTES_W'(STATUS_QUEUE_BYTES);                 // R16
            TX_DATA_BYTES  <= tx_total - BUF_BYTES_W'(STATUS_QUEUE_BYTES);      // R16
            RX_TOTAL_BYTES <= BUF_BYTES_W'(TOTAL_BUFFER_BYTES) - tx_total;     // R17
        end
    end
endmodule // tx_buffer_split

// file: tx_hw_config_regs.sv
// Transmit control and hardware configuration registers
// Notes on behaviour
// [R1] Bit 15 write flushes status queue, self-clears
// [R2] Bit 14 write flushes data queue, self-clears
// [R3] Overrun allow clear: pause when status full
// [R4] Status full interrupt ignores overrun allow
// [R5] Transmitter-on bit enables sending queued data
// [R6] Transmitter-on clears after stop and halt
// [R7] Stop finishes current frame, then self-clears
// [R8] Stop bit writes ignored while it is high
// [R9] Host halts transmit and receive before configuring
// [R10] Bit 29 sets data port byte order
// [R11] Bit 28 sets direct select byte order
// [R12] Byte order bits survive soft reset
// [R13] Bit 24 shows sampled crossover strap
// [R14] Host writes one to bit 20
// [R15] Bits 19:16 set transmit allocation, reset 5
// [R16] Status queue fixed 512 bytes, data rest
// [R17] Receive gets 16KB minus transmit share
// [R18] Host uses allocation codes 2 to 14 only
// [R19] Soft reset without PHY clocks times out
// [R20] Host fixes PHY, retries soft reset
// [R21] Bit 0 starts soft reset, self-clears
// [R22] Reserved bits read zero, ignore writes
`timescale 1ns/1ps
module tx_hw_config_regs
    import txhw_cfg_pkg::*;
#(
    parameter int SOFT_RESET_TRIGGER_TIMEOUT = SOFT_RESET_TRIGGER_TIMEOUT_CYCLES  // Cycles to wait for PHY clocks
)(
    input  wire logic                   CLK,              // System clock, 20 MHz
    input  wire logic                   NRST,             // Async reset, active low
    input  wire logic [7:0]             ADDR,             // Register byte address
    input  wire logic [31:0]            WDATA,            // Write data
    input  wire logic                   WR,               // Write strobe
    input  wire logic                   RD,               // Read strobe
    output logic      [31:0]            RDATA,            // Read data, cycle after RD
    input  wire logic                   CROSSOVER_STRAP,  // Crossover strap level
    input  wire logic                   PHY_CLOCKS_OK,    // PHY receive and transmit clocks run
    input  wire logic                   TX_FRAME_BUSY,    // Frame in progress on the wire
    input  wire logic                   TX_STATUS_FULL,   // Transmit status queue full
    output logic                        TX_ENABLE,        // Transmitter enabled
    output logic                        TX_SEND_OK,       // Transmitter may start frames
    output logic                        TX_HALTED,        // Transmitter stopped
    output logic                        TX_STATUS_FULL_EVENT, // Status full interrupt source
    output logic                        TX_STATUS_FLUSH,  // Zero status queue pointers
    output logic                        TX_DATA_FLUSH,    // Zero data queue pointers
    output logic                        PORT_BYTE_ORDER,  // Data port big endian
    output logic                        SELECT_BYTE_ORDER, // Direct select big endian
    output logic                        MUST_SET_BIT,     // Normal operation bit
    output logic      [HWC_ALLOC_W-1:0] TX_ALLOC,         // Transmit allocation in KB
    output logic      [BUF_BYTES_W-1:0] TX_DATA_BYTES,    // Transmit data queue size
    output logic      [BUF_BYTES_W-1:0] TX_STAT_BYTES,    // Transmit status queue size
    output logic      [BUF_BYTES_W-1:0] RX_TOTAL_BYTES,   // Receive share size
    output logic                        SOFT_RESET_OUT    // Soft reset pulse to other CSRs
);
    typedef enum {SR_IDLE, SR_WAIT, SR_PULSE} soft_reset_trigger_state_t;

    soft_reset_trigger_state_t state;
    logic        wr_tx;
    logic        wr_hw;
    logic        rd_tx;
    logic        rd_hw;
    logic        stop_done;
    logic        soft_reset_trigger_start;
    logic        wait_done;
    logic        pulse_done;
    logic        stop_req;
    logic        overrun_allow;
    logic        soft_reset_busy;
    logic        timeout_flag;
    logic        strap_seen;
    logic        soft_clear;
    logic [31:0] count;
    logic [31:0] tx_word;
    logic [31:0] hw_word;

    // Strobe aimed at one register offset
    function automatic logic hits(input logic       strobe,
                                  input logic [7:0] addr,
                                  input logic [7:0] offset);
        return strobe && (addr == offset);
    endfunction

    // True once a counter has reached the last cycle of a span
    function automatic logic span_done(input logic [31:0] cnt, input int span);
        return cnt >= 32'(span - 1);
    endfunction

    // Register strobes and sequencer decode
    assign wr_tx      = hits(WR, ADDR, TX_CTRL_OFFSET);
    assign wr_hw      = hits(WR, ADDR, HARDWARE_CONFIGURATION_OFFSET);
    assign rd_tx      = hits(RD, ADDR, TX_CTRL_OFFSET);
    assign rd_hw      = hits(RD, ADDR, HARDWARE_CONFIGURATION_OFFSET);
    assign soft_clear = (state == SR_PULSE);
    assign soft_reset_trigger_start = wr_hw && WDATA[HWC_SOFT_RESET] && (state == SR_IDLE); // R21
    assign wait_done  = span_done(count, SOFT_RESET_TRIGGER_TIMEOUT);
    assign pulse_done = span_done(count, SOFT_RESET_TRIGGER_PULSE_CYCLES);
    assign stop_done  = stop_req && !TX_FRAME_BUSY;                           // R6 R7

    // Status queue flush pulse, one cycle per written one
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_STATUS_FLUSH <= 1'b0;
        end else begin
            TX_STATUS_FLUSH <= wr_tx && WDATA[TXC_STATUS_FLUSH];  // R1
        end
    end

    // Data queue flush pulse, one cycle per written one
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_DATA_FLUSH <= 1'b0;
        end else begin
            TX_DATA_FLUSH <= wr_tx && WDATA[TXC_DATA_FLUSH];      // R2
        end
    end

    // Overrun permission
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            overrun_allow <= 1'b0;
        end else if (soft_clear) begin
            overrun_allow <= 1'b0;
        end else if (wr_tx) begin
            overrun_allow <= WDATA[TXC_OVERRUN_ALLOW];
        end
    end

    // Transmitter on bit; a host write of one wins over the stop clearing it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_ENABLE <= 1'b0;
        end else if (soft_clear) begin
            TX_ENABLE <= 1'b0;
        end else if (wr_tx && WDATA[TXC_ON]) begin
            TX_ENABLE <= 1'b1;                                     // R5
        end else if (stop_done) begin
            TX_ENABLE <= 1'b0;                                     // R6
        end else if (wr_tx) begin
            TX_ENABLE <= 1'b0;                                     // R5
        end
    end

    // Stop request; writes to it are ignored while it reads high
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            stop_req <= 1'b0;
        end else if (soft_clear) begin
            stop_req <= 1'b0;
        end else if (stop_done) begin
            stop_req <= 1'b0;                                      // R7
        end else if (wr_tx && !stop_req) begin                     // R8
            stop_req <= WDATA[TXC_STOP];                           // R7
        end
    end

    // Halt status for the queue logic
    assign TX_HALTED            = !TX_ENABLE && !TX_FRAME_BUSY;

    // Frame start permission, held back by a full status queue while overrun allow is clear
    assign TX_SEND_OK           = TX_ENABLE && !stop_req
                                  && (overrun_allow || !TX_STATUS_FULL); // R3 R5 R7

    // Status full interrupt source, blind to the overrun permission
    assign TX_STATUS_FULL_EVENT = TX_STATUS_FULL;                        // R4

    // Byte order bits, untouched by soft reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PORT_BYTE_ORDER   <= 1'b0;
            SELECT_BYTE_ORDER <= 1'b0;
        end else if (wr_hw) begin                                  // R12
            PORT_BYTE_ORDER   <= WDATA[HWC_PORT_ORDER];            // R10
            SELECT_BYTE_ORDER <= WDATA[HWC_SELECT_ORDER];          // R11
        end
    end

    // Must-set bit, lost on soft reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            MUST_SET_BIT <= 1'b0;
        end else if (soft_clear) begin
            MUST_SET_BIT <= 1'b0;
        end else if (wr_hw) begin
            MUST_SET_BIT <= WDATA[HWC_MUST_SET];
        end
    end

    // Transmit allocation, back to its default on soft reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_ALLOC <= ALLOC_RESET;                               // R15
        end else if (soft_clear) begin
            TX_ALLOC <= ALLOC_RESET;
        end else if (wr_hw) begin
            TX_ALLOC <= WDATA[HWC_ALLOC_LSB +: HWC_ALLOC_W];       // R15
        end
    end

    // Strap followed by a clocked sample on every cycle after reset release
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            strap_seen <= 1'b0;
        end else begin
            strap_seen <= CROSSOVER_STRAP;                         // R13
        end
    end

    // Soft reset sequence: wait for the PHY clocks, then pulse
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= SR_IDLE;
        end else begin
            case (state)
                SR_IDLE: begin
                    if (soft_reset_trigger_start) begin
                        state <= SR_WAIT;                          // R21
                    end
                end
                SR_WAIT: begin
                    if (PHY_CLOCKS_OK) begin
                        state <= SR_PULSE;
                    end else if (wait_done) begin
                        state <= SR_IDLE;                          // R19
                    end
                end
                SR_PULSE: begin
                    if (pulse_done) begin
                        state <= SR_IDLE;                          // R21
                    end
                end
                default: begin
                    state <= SR_IDLE;
                end
            endcase
        end
    end

    // Cycle counter, restarted on entry to waiting and to pulsing
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            count <= '0;
        end else if (soft_reset_trigger_start || (state == SR_WAIT && PHY_CLOCKS_OK)) begin
            count <= '0;
        end else if (state == SR_WAIT && !wait_done) begin
            count <= count + 32'd1;
        end else if (state == SR_PULSE && !pulse_done) begin
            count <= count + 32'd1;
        end
    end

    // Timeout flag, set if the PHY clocks never came, cleared by a new request
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            timeout_flag <= 1'b0;
        end else if (state == SR_WAIT && !PHY_CLOCKS_OK && wait_done) begin
            timeout_flag <= 1'b1;                                  // R19
        end else if (soft_reset_trigger_start) begin
            timeout_flag <= 1'b0;
        end
    end

    // Busy status and reset pulse to the other registers
    assign soft_reset_busy = (state != SR_IDLE);
    assign SOFT_RESET_OUT  = soft_clear;

    // Transmit control read word, reserved bits zero
    always_comb begin
        tx_word                    = '0;                           // R22
        tx_word[TXC_OVERRUN_ALLOW] = overrun_allow;
        tx_word[TXC_ON]            = TX_ENABLE;
        tx_word[TXC_STOP]          = stop_req;
    end

    // Hardware configuration read word, reserved bits zero
    always_comb begin
        hw_word                    = '0;                           // R22
        hw_word[HWC_PORT_ORDER]    = PORT_BYTE_ORDER;
        hw_word[HWC_SELECT_ORDER]  = SELECT_BYTE_ORDER;
        hw_word[HWC_CROSSOVER]     = strap_seen;                   // R13
        hw_word[HWC_MUST_SET]      = MUST_SET_BIT;
        hw_word[HWC_ALLOC_LSB +: HWC_ALLOC_W] = TX_ALLOC;
        hw_word[HWC_RESET_TIMEOUT] = timeout_flag;                 // R19
        hw_word[HWC_SOFT_RESET]    = soft_reset_busy;              // R21
    end

    // Read data register, zero for unmapped addresses
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= '0;
        end else if (rd_tx) begin
            RDATA <= tx_word;
        end else if (rd_hw) begin
            RDATA <= hw_word;
        end else begin
            RDATA <= '0;
        end
    end

    // Buffer split from allocation
    tx_buffer_split u_split (
        .CLK            (CLK),
        .NRST           (NRST),
        .ALLOC          (TX_ALLOC),
        .TX_DATA_BYTES  (TX_DATA_BYTES),
        .TX_STAT_BYTES  (TX_STAT_BYTES),
        .RX_TOTAL_BYTES (RX_TOTAL_BYTES)
    );
endmodule // tx_hw_config_regs

// file: txhw_cfg_pkg.sv
// Package with offsets, fields, reset values and timing for the TX and hardware config registers
package txhw_cfg_pkg;
    // Register byte offsets
    localparam logic [7:0] TX_CTRL_OFFSET      = 8'h70;
    localparam logic [7:0] HARDWARE_CONFIGURATION_OFFSET       = 8'h74;
    // Transmit control fields
    localparam int         TXC_STATUS_FLUSH    = 15;
    localparam int         TXC_DATA_FLUSH      = 14;
    localparam int         TXC_OVERRUN_ALLOW   = 2;
    localparam int         TXC_ON              = 1;
    localparam int         TXC_STOP            = 0;
    // Hardware configuration fields
    localparam int         HWC_PORT_ORDER      = 29;
    localparam int         HWC_SELECT_ORDER    = 28;
    localparam int         HWC_CROSSOVER       = 24;
    localparam int         HWC_MUST_SET        = 20;
    localparam int         HWC_ALLOC_LSB       = 16;
    localparam int         HWC_ALLOC_W         = 4;
    localparam int         HWC_RESET_TIMEOUT   = 1;
    localparam int         HWC_SOFT_RESET      = 0;
    // Reset values
    localparam logic [3:0] ALLOC_RESET         = 4'h5;
    // Buffer sizing in bytes
    localparam int         TOTAL_BUFFER_BYTES  = 16384;
    localparam int         KB_BYTES            = 1024;
    localparam int         STATUS_QUEUE_BYTES  = 512;
    localparam int         BUF_BYTES_W         = 15;
    // Soft reset wait for the PHY clocks: time in ns and derived cycles
    localparam int         CLK_PERIOD_NS       = 50;
    localparam int         SOFT_RESET_TRIGGER_TIMEOUT_NS     = 100000;
    localparam int         SOFT_RESET_TRIGGER_TIMEOUT_CYCLES = SOFT_RESET_TRIGGER_TIMEOUT_NS / CLK_PERIOD_NS;
    // Cycles of soft reset pulse once the PHY clocks are running
    localparam int         SOFT_RESET_TRIGGER_PULSE_CYCLES   = 4;
endpackage

// file: txhw_chk_assertions.sv
// Port checks for the config register block
`timescale 1ns/1ps
module txhw_chk
    import txhw_cfg_pkg::*;
(
    input wire logic                   CLK,                  // Clock
    input wire logic                   NRST,                 // Reset
    input wire logic [7:0]             ADDR,                 // Address
    input wire logic [31:0]            WDATA,                // Data
    input wire logic                   WR,                   // Write
    input wire logic                   TX_FRAME_BUSY,        // Busy
    input wire logic                   TX_STATUS_FULL,       // Full
    input wire logic                   PHY_CLOCKS_OK,        // PHY
    input wire logic                   TX_ENABLE,            // Enable
    input wire logic                   TX_SEND_OK,           // Permit
    input wire logic                   TX_STATUS_FULL_EVENT, // Event
    input wire logic                   TX_STATUS_FLUSH,      // Flush
    input wire logic                   TX_DATA_FLUSH,        // Flush
    input wire logic [HWC_ALLOC_W-1:0] TX_ALLOC,             // Share
    input wire logic [BUF_BYTES_W-1:0] TX_DATA_BYTES,        // Size
    input wire logic [BUF_BYTES_W-1:0] RX_TOTAL_BYTES,       // Size
    input wire logic                   SOFT_RESET_OUT        // Reset
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Decoded writes and last written overrun permission
    wire logic wtx = WR && ADDR == TX_CTRL_OFFSET;
    wire logic whw = WR && ADDR == HARDWARE_CONFIGURATION_OFFSET;
    logic      allow;
    always_ff @(posedge CLK or negedge NRST)
        if (!NRST) allow <= 1'h0;
        else if (SOFT_RESET_OUT) allow <= 1'h0;
        else if (wtx) allow <= WDATA[TXC_OVERRUN_ALLOW];
    AST_SFLUSH: assert property (wtx && WDATA[TXC_STATUS_FLUSH] |=> TX_STATUS_FLUSH)
        else $error("status flush missing");
    AST_DFLUSH: assert property (wtx && WDATA[TXC_DATA_FLUSH] |=> TX_DATA_FLUSH)
        else $error("data flush missing");
    AST_FULL: assert property (TX_SEND_OK && TX_STATUS_FULL |-> allow)
        else $error("sending on full status");
    AST_EVENT: assert property (TX_STATUS_FULL_EVENT == TX_STATUS_FULL)
        else $error("full event wrong");
    AST_ON: assert property (TX_SEND_OK |-> TX_ENABLE)
        else $error("send without enable");
    AST_OFF: assert property ($fell(TX_ENABLE) && !$past(wtx) && !$past(SOFT_RESET_OUT)
        |-> !$past(TX_FRAME_BUSY)) else $error("enable dropped mid frame");
    AST_ALLOC: assert property (whw && !SOFT_RESET_OUT |=> TX_ALLOC ==
        $past(WDATA[HWC_ALLOC_LSB +: HWC_ALLOC_W])) else $error("share not written");
    AST_SIZE: assert property ($past(NRST) |->
        TX_DATA_BYTES == 15'($past(TX_ALLOC) * KB_BYTES - STATUS_QUEUE_BYTES) &&
        RX_TOTAL_BYTES == 15'(TOTAL_BUFFER_BYTES - $past(TX_ALLOC) * KB_BYTES))
        else $error("buffer split wrong");
    AST_SOFT_RESET_TRIGGER: assert property (whw && WDATA[HWC_SOFT_RESET] && PHY_CLOCKS_OK
        && !SOFT_RESET_OUT |-> ##[1:4] SOFT_RESET_OUT) else $error("soft reset missing");
    cover property (wtx && WDATA[TXC_STOP]);
    cover property ($fell(TX_ENABLE));
    cover property ($rose(SOFT_RESET_OUT));
endmodule // txhw_chk
bind tx_hw_config_regs txhw_chk u_txhw_chk (.CLK, .NRST, .ADDR, .WDATA, .WR, .TX_FRAME_BUSY,
    .TX_STATUS_FULL, .PHY_CLOCKS_OK, .TX_ENABLE, .TX_SEND_OK, .TX_STATUS_FULL_EVENT,
    .TX_STATUS_FLUSH, .TX_DATA_FLUSH, .TX_ALLOC, .TX_DATA_BYTES, .RX_TOTAL_BYTES,
    .SOFT_RESET_OUT);

// file: txhw_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
module txhw_host (
    input  wire logic        CLK,            // Clock
    output logic      [7:0]  ADDR  = 8'h0,   // Address
    output logic      [31:0] WDATA = 32'h0,  // Write data
    output logic             WR    = 1'h0,   // Write strobe
    output logic             RD    = 1'h0,   // Read strobe
    input  wire logic [31:0] RDATA           // Read data
);
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'h1;
        @(posedge CLK);
        WR    <= 1'h0;
        #1;
    endtask
    // One-cycle read strobe, data taken in the next cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'h1;
        @(posedge CLK);
        RD   <= 1'h0;
        #1;
        v = RDATA;
    endtask
endmodule // txhw_host
